// *** ir_adc_cfg.svh ***
/*
  Register indices, field positions, reset values and timing constants
  for the ambient infrared converter timing block.
  Assumes it is included by bare name into the package and the top module.
*/
`ifndef IR_ADC_CFG_SVH
`define IR_ADC_CFG_SVH

// Register indices; byte address is four times the index
`define IRC_IDX_SPARE      6'h1c
`define IRC_IDX_RECOV      6'h1d
`define IRC_IDX_GAIN       6'h1e
`define IRC_IDX_RANGE      6'h1f
`define IRC_IDX_CTRL       6'h20
`define IRC_IDX_STAT       6'h21

// Reset values
`define IRC_RST_SPARE      8'h00
`define IRC_RST_RECOV      8'h70
`define IRC_RST_GAIN       8'h00
`define IRC_RST_RANGE      8'h00

// Field positions
`define IRC_REC_MSB        6
`define IRC_REC_LSB        4
`define IRC_GAIN_MSB       2
`define IRC_GAIN_LSB       0
`define IRC_RANGE_BIT      5
`define IRC_CTRL_START_BIT 0

// AXI responses
`define IRC_RESP_OKAY      2'h0
`define IRC_RESP_SLVERR    2'h2

// Timing: one converter clock, and the system clock period
`define IRC_ADC_CLK_NS     50
`define IRC_SYS_CLK_NS     50
`define IRC_ADC_CLK_CYC    (`IRC_ADC_CLK_NS / `IRC_SYS_CLK_NS)

// Base integration length in converter clocks before the gain multiplier
`define IRC_INT_CLOCKS     16'h0040

`endif

// *** ir_adc_pkg.sv ***
/*
  Types for the ambient infrared converter timing block.
  Assumes ir_adc_cfg.svh is on the include path.
*/
`default_nettype none
`include "ir_adc_cfg.svh"

package ir_adc_pkg;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RECOVER, SEQ_INTEGRATE} seq_e;

  typedef struct packed {
    logic busy;
    logic recovering;
    logic integrating;
    logic high_range;
    logic conv_tick;
    logic done;
  } ir_stat_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_hold;
    logic [5:0]  aw_idx;
    logic        w_hold;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  spare_emitter_param;
    logic [7:0]  ir_recovery_config;
    logic [7:0]  ir_gain_config;
    logic [7:0]  ir_high_range_select_config;
    seq_e        seq;
    logic [6:0]  pre_cnt;
    logic [8:0]  rec_cnt;
    logic [15:0] int_cnt;
    logic [2:0]  gain_snap;
    logic [2:0]  rcode_snap;
    ir_stat_s    stat;
    logic [23:0] rec_len;
    logic [23:0] int_len;
    logic [23:0] gap;
  } ir_state_s;

endpackage

`default_nettype wire

// *** ir_adc_timing.sv ***
/*
  Ambient infrared converter timing: AXI4-Lite register slave and the
  recovery/integration sequencer with gain-based converter clock divider.
  Assumes CLK is the 50 ns converter clock and IR_MEAS_REQ comes from
  logic on the same clock.
*/
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ir_adc_cfg.svh"

module ir_adc_timing #(
  parameter logic [7:0]  SEQ_REV    = 8'h10,  // Arbitrary value
  parameter logic [7:0]  MIN_REV    = 8'h10,  // Arbitrary value
  parameter logic [15:0] INT_CLOCKS = `IRC_INT_CLOCKS
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 SYS_RST,
  // AXI4-Lite write
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  // Measurement request and converter status
  input  wire logic                 IR_MEAS_REQ,
  output var ir_adc_pkg::ir_stat_s  IR_STAT
);

  localparam ir_adc_pkg::ir_state_s ST_RST = '{
    awready:             1'b1,
    wready:              1'b1,
    arready:             1'b1,
    spare_emitter_param: `IRC_RST_SPARE,
    ir_recovery_config:  `IRC_RST_RECOV,
    ir_gain_config:      `IRC_RST_GAIN,
    ir_high_range_select_config:     `IRC_RST_RANGE,
    seq:                 ir_adc_pkg::SEQ_IDLE,
    default:             '0
  };

  if (INT_CLOCKS == 16'h0000) begin : g_chk_int
    $error("INT_CLOCKS must be at least one");
  end
  if (`IRC_ADC_CLK_CYC != 1) begin : g_chk_clk
    $error("Converter clock must equal the system clock");
  end

  ir_adc_pkg::ir_state_s s_r;
  ir_adc_pkg::ir_state_s s_nxt;

  logic       feature_on;
  logic [2:0] eff_gain;
  logic [2:0] eff_rcode;
  logic       eff_range;

  // Older sequencers behave as if the recovery, gain and range settings were zero
  assign feature_on = (SEQ_REV >= MIN_REV);
  assign eff_gain   = feature_on ? s_r.ir_gain_config[`IRC_GAIN_MSB:`IRC_GAIN_LSB] : 3'h0;
  assign eff_rcode  = feature_on ? s_r.ir_recovery_config[`IRC_REC_MSB:`IRC_REC_LSB] : 3'h0;
  assign eff_range  = feature_on ? s_r.ir_high_range_select_config[`IRC_RANGE_BIT] : 1'b0;

  // Code 0 is one clock, code n is 2^(n+2)-1 clocks
  function automatic logic [8:0] rec_clocks(input logic [2:0] code);
    logic [9:0] t;
    t = 10'h004 << code;
    rec_clocks = (code == 3'h0) ? 9'h001 : t[8:0] - 9'h001;
  endfunction

  always_comb begin
    logic [7:0] msk;
    logic       tick;
    logic       start;
    msk   = 8'h00;
    tick  = 1'b0;
    start = IR_MEAS_REQ;
    s_nxt = s_r;

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && s_r.awready) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_idx  = S_AXI_AWADDR[7:2];
    end
    if (S_AXI_WVALID && s_r.wready) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wdata  = S_AXI_WDATA[7:0];
      s_nxt.wstrb0 = S_AXI_WSTRB[0];
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `IRC_RESP_OKAY;
      case (s_r.aw_idx)
        `IRC_IDX_SPARE: begin
          if (s_r.wstrb0) s_nxt.spare_emitter_param = s_r.wdata;
        end
        `IRC_IDX_RECOV: begin
          if (s_r.wstrb0 && feature_on) s_nxt.ir_recovery_config = s_r.wdata;
        end
        `IRC_IDX_GAIN: begin
          if (s_r.wstrb0 && feature_on) s_nxt.ir_gain_config = s_r.wdata;
        end
        `IRC_IDX_RANGE: begin
          // Reserved bits stored as written so read-modify-write keeps them
          if (s_r.wstrb0 && feature_on) s_nxt.ir_high_range_select_config = s_r.wdata;
        end
        `IRC_IDX_CTRL: begin
          if (s_r.wstrb0 && s_r.wdata[`IRC_CTRL_START_BIT]) start = 1'b1;
        end
        `IRC_IDX_STAT: begin
        end
        default: begin
          s_nxt.bresp = `IRC_RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_hold && !s_nxt.bvalid;

    // Read channel: answer one cycle after the address is taken
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `IRC_RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      case (S_AXI_ARADDR[7:2])
        `IRC_IDX_SPARE: s_nxt.rdata[7:0] = s_r.spare_emitter_param;
        `IRC_IDX_RECOV: s_nxt.rdata[7:0] = feature_on ? s_r.ir_recovery_config : 8'h00;
        `IRC_IDX_GAIN:  s_nxt.rdata[7:0] = feature_on ? s_r.ir_gain_config : 8'h00;
        `IRC_IDX_RANGE: s_nxt.rdata[7:0] = feature_on ? s_r.ir_high_range_select_config : 8'h00;
        `IRC_IDX_CTRL: begin
        end
        `IRC_IDX_STAT: begin
          s_nxt.rdata = {16'h0000, SEQ_REV, 4'h0, feature_on, s_r.stat.integrating,
                         s_r.stat.recovering, s_r.stat.busy};
        end
        default: s_nxt.rresp = `IRC_RESP_SLVERR;
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Sequencer; a request while busy is dropped
    msk              = (8'h01 << s_r.gain_snap) - 8'h01;
    tick             = (s_r.pre_cnt == msk[6:0]);
    s_nxt.stat.done      = 1'b0;
    s_nxt.stat.conv_tick = 1'b0;
    case (s_r.seq)
      ir_adc_pkg::SEQ_IDLE: begin
        if (start) begin
          s_nxt.seq        = ir_adc_pkg::SEQ_RECOVER;
          s_nxt.gain_snap  = eff_gain;
          s_nxt.rcode_snap = eff_rcode;
          s_nxt.stat.high_range = eff_range;
          s_nxt.pre_cnt    = 7'h00;
          s_nxt.rec_cnt    = rec_clocks(eff_rcode);
        end
      end
      ir_adc_pkg::SEQ_RECOVER: begin
        s_nxt.pre_cnt        = tick ? 7'h00 : s_r.pre_cnt + 7'h01;
        s_nxt.stat.conv_tick = tick;
        if (tick) begin
          if (s_r.rec_cnt == 9'h001) begin
            s_nxt.seq     = ir_adc_pkg::SEQ_INTEGRATE;
            s_nxt.int_cnt = INT_CLOCKS;
          end else begin
            s_nxt.rec_cnt = s_r.rec_cnt - 9'h001;
          end
        end
      end
      ir_adc_pkg::SEQ_INTEGRATE: begin
        s_nxt.pre_cnt        = tick ? 7'h00 : s_r.pre_cnt + 7'h01;
        s_nxt.stat.conv_tick = tick;
        if (tick) begin
          if (s_r.int_cnt == 16'h0001) begin
            s_nxt.seq       = ir_adc_pkg::SEQ_IDLE;
            s_nxt.stat.done = 1'b1;
          end else begin
            s_nxt.int_cnt = s_r.int_cnt - 16'h0001;
          end
        end
      end
      default: s_nxt.seq = ir_adc_pkg::SEQ_IDLE;
    endcase
    s_nxt.stat.busy        = (s_nxt.seq != ir_adc_pkg::SEQ_IDLE);
    s_nxt.stat.recovering  = (s_nxt.seq == ir_adc_pkg::SEQ_RECOVER);
    s_nxt.stat.integrating = (s_nxt.seq == ir_adc_pkg::SEQ_INTEGRATE);

    // Phase lengths and tick spacing, kept only for the checks below
    s_nxt.rec_len = s_r.stat.recovering ? s_r.rec_len + 24'h000001 : 24'h000000;
    s_nxt.int_len = s_r.stat.integrating ? s_r.int_len + 24'h000001 : 24'h000000;
    if (s_r.stat.conv_tick) begin
      s_nxt.gap = 24'h000001;
    end else if (s_r.gap != 24'hffffff) begin
      s_nxt.gap = s_r.gap + 24'h000001;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY  = s_r.wready;
  assign S_AXI_BVALID  = s_r.bvalid;
  assign S_AXI_BRESP   = s_r.bresp;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_RVALID  = s_r.rvalid;
  assign S_AXI_RRESP   = s_r.rresp;
  assign S_AXI_RDATA   = s_r.rdata;
  assign IR_STAT       = s_r.stat;

  // Expected phase lengths for the checks below
  logic [23:0] exp_rec;
  logic [23:0] exp_int;
  assign exp_rec = {15'h0000, rec_clocks(s_r.rcode_snap)} << s_r.gain_snap;
  assign exp_int = {8'h00, INT_CLOCKS} << s_r.gain_snap;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_recovery_len: assert property ($fell(s_r.stat.recovering) |-> s_r.rec_len == exp_rec)
    else $error("Recovery length differs from code and gain");
  a_integ_len: assert property ($fell(s_r.stat.integrating) |-> s_r.int_len == exp_int)
    else $error("Integration length not scaled by gain");
  a_div_period: assert property (s_r.stat.conv_tick && s_r.stat.busy &&
      s_r.gap <= ({21'h000000, 3'h1} << s_r.gain_snap) |->
      s_r.gap == (24'h000001 << s_r.gain_snap))
    else $error("Converter clock divide ratio wrong");
  a_range_take: assert property ($rose(s_r.stat.recovering) |-> s_r.stat.high_range == $past(eff_range))
    else $error("Range select not taken at start");
  a_old_rev: assert property (!feature_on && s_r.stat.busy |->
      s_r.gain_snap == 3'h0 && s_r.rcode_snap == 3'h0 && !s_r.stat.high_range)
    else $error("Settings active on an old sequencer");
  a_integ_after: assert property ($rose(s_r.stat.integrating) |-> $past(s_r.stat.recovering))
    else $error("Integration began without recovery");
  a_done_pulse: assert property (s_r.stat.done |-> !s_r.stat.integrating ##1 !s_r.stat.done)
    else $error("Done is not a single pulse after integration");
  a_bresp_hold: assert property (s_r.bvalid && !S_AXI_BREADY |=> s_r.bvalid)
    else $error("Write response dropped before taken");

endmodule // ir_adc_timing

`default_nettype wire

// *** ir_ambient_adc_timing_config_bench.sv ***
/*
  Self-checking bench for the ambient infrared converter timing block.
  Assumes ir_adc_pkg.sv and ir_adc_timing.sv are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module ir_ambient_adc_timing_config_bench;
  // Short integration keeps each conversion under a thousand cycles
  localparam int INT_CLK = 2;

  logic                 clk;
  logic                 sys_rst;
  logic [7:0]           awaddr;
  logic                 awvalid;
  logic                 awready;
  logic [31:0]          wdata;
  logic                 wvalid;
  logic                 wready;
  logic [1:0]           bresp;
  logic                 bvalid;
  logic                 bready;
  logic [7:0]           araddr;
  logic                 arvalid;
  logic                 arready;
  logic [31:0]          rdata;
  logic [1:0]           rresp;
  logic                 rvalid;
  logic                 rready;
  logic                 meas_req;
  ir_adc_pkg::ir_stat_s stat;
  ir_adc_pkg::ir_stat_s stat_old;
  logic [31:0]          rdata_old;
  logic [3:0]           wstrb;
  int                   num_errors;
  int                   compares;

  ir_adc_timing #(.SEQ_REV(8'h10), .MIN_REV(8'h10), .INT_CLOCKS(16'(INT_CLK)))
    i_ir_adc_timing (
    .CLK(clk), .SYS_RST(sys_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IR_MEAS_REQ(meas_req), .IR_STAT(stat));

  // Sequencer older than the minimum revision: settings must stay inert
  ir_adc_timing #(.SEQ_REV(8'h0f), .MIN_REV(8'h10), .INT_CLOCKS(16'(INT_CLK)))
    i_ir_adc_timing_old (
    .CLK(clk), .SYS_RST(sys_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
    .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(),
    .S_AXI_RDATA(rdata_old), .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready),
    .IR_MEAS_REQ(meas_req), .IR_STAT(stat_old));

  task automatic final_report;
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang(input string what);
    num_errors++;
    $display("ERROR %s expected completion seen timeout", what);
    final_report();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 100) hang("write");
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 100) hang("read");
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check("rdata", d, exp);
    check("rresp", {30'h0, r}, 32'h0);
  endtask

  // Counts each phase of one conversion; recovery length is R times 2^gain
  task automatic conv(input logic [2:0] c, input logic [2:0] g, input logic hr);
    int rec, integ, ticks, n, rcl, rec_o, integ_o;
    logic [1:0] r;
    rcl = (c == 3'h0) ? 1 : (1 << (c + 2)) - 1;
    axi_wr(8'h74, {25'h0, c, 4'h0}, r);
    axi_wr(8'h78, {29'h0, g}, r);
    @(posedge clk);
    meas_req <= 1'b1;
    @(posedge clk);
    meas_req <= 1'b0;
    rec = 0;
    integ = 0;
    ticks = 0;
    rec_o = 0;
    integ_o = 0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      rec_o += int'(stat_old.recovering);
      integ_o += int'(stat_old.integrating);
      rec += int'(stat.recovering);
      integ += int'(stat.integrating);
      ticks += int'(stat.conv_tick);
      if (n > 70000) hang("conversion");
    end while (stat.busy === 1'b1);
    check("recover", 32'(rec), 32'(rcl << g));
    check("integrate", 32'(integ), 32'(INT_CLK << g));
    check("conv_tick", 32'(ticks), 32'(rcl + INT_CLK));
    check("done", {31'h0, stat.done}, 32'h1);
    check("high_range", {31'h0, stat.high_range}, {31'h0, hr});
    check("old recover", 32'(rec_o), 32'h1);
    check("old integrate", 32'(integ_o), 32'(INT_CLK));
    check("old high_range", {31'h0, stat_old.high_range}, 32'h0);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(8'h70, 32'h0);
    rd_chk(8'h74, 32'h70);
    check("old recovery", rdata_old, 32'h0);
    rd_chk(8'h78, 32'h0);
    rd_chk(8'h7c, 32'h0);
    axi_wr(8'h70, 32'hffffffa5, r);
    rd_chk(8'h70, 32'ha5);
    wstrb <= 4'h0;
    axi_wr(8'h70, 32'h5a, r);
    wstrb <= 4'hf;
    check("bresp", {30'h0, r}, 32'h0);
    rd_chk(8'h70, 32'ha5);
    axi_wr(8'h00, 32'h1, r);
    check("bresp", {30'h0, r}, 32'h2);
    axi_rd(8'h00, d, r);
    check("rresp", {30'h0, r}, 32'h2);
  endtask

  task automatic t_range;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h7c, 32'h1a, r);
    axi_rd(8'h7c, d, r);
    axi_wr(8'h7c, d | 32'h20, r);
    rd_chk(8'h7c, 32'h3a);
    check("old range", rdata_old, 32'h0);
    conv(3'h0, 3'h0, 1'b1);
    axi_rd(8'h7c, d, r);
    axi_wr(8'h7c, d & ~32'h20, r);
    conv(3'h1, 3'h2, 1'b0);
  endtask

  // Every recovery code and every gain exponent once
  task automatic t_codes;
    for (int k = 0; k < 8; k++) begin
      conv(3'(k), 3'(7 - k), 1'b0);
    end
  endtask

  task automatic t_ctrl;
    logic [1:0] r;
    int n;
    axi_wr(8'h74, 32'h70, r);
    axi_wr(8'h78, 32'h0, r);
    axi_wr(8'h80, 32'h1, r);
    rd_chk(8'h84, 32'h0000100b);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 1000) hang("control start");
    end while (stat.busy === 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    meas_req = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_range();
    t_codes();
    t_ctrl();
    final_report();
  end
endmodule // ir_ambient_adc_timing_config_bench

`default_nettype wire
